// File: rtl/scrb_pkg.sv
/*
 Package for the stepper control register bank: register addresses,
 field positions, reset values and the packed configuration carrier.
 Assumes a 16-bit serial frame (address byte, then data byte), MSB first.
*/
// Behaviour
// RULE1 - Each byte shifts out data held at the most recently received address.
// RULE2 - Config bit 7 at 0x01 inverts the rotation sense pin.
// RULE3 - Hold equals NOT(run/hold pin XOR config bit 6 at 0x01).
// RULE4 - Bit 5 at 0x01 is a software step trigger.
// RULE5 - Bit 4 at 0x01 enables both H-bridges; cleared keeps them off.
// RULE6 - Bits 3..0 at 0x01 are stall level; zero disables stall detection.
// RULE7 - Register 0x02 holds hold current high nibble, run current low nibble.
// RULE8 - Bit 7 at 0x03 enables enhanced back-EMF measurement.
// RULE9 - Bit 6 at 0x03 starts diagnostic on each bridge enable rise.
// RULE10 - Bits 5..4 at 0x03 select driver slew rate.
// RULE11 - Bit 3 at 0x03 requests sleep; bits 2..0 select step resolution.
// RULE12 - Register 0x04 holds stall timeout between full-step periods.
// RULE13 - Back-EMF and stall active only when speed is at most 0x05 value.
// RULE14 - Register 0x06 holds undervolt level one high, level two low.
// RULE15 - Bit 7 at 0x07 supplies the upper address bit.
// RULE16 - Bit 6 at 0x07 selects back-EMF gain, 0.5 or 0.25.
// RULE17 - Bits 5..0 at 0x07 enable six individual interrupt sources.
// RULE18 - Bit 4 at 0x14 activates boost and reports boost in effect.
// RULE19 - Bits 3..2 at 0x14 select open-coil detection time.
// RULE20 - Bit 1 at 0x14 flags open coil only, drivers stay active.
// RULE21 - Bit 0 at 0x14 floats drivers on open coil unless bit 1 set.
// RULE22 - Address in upper nibble writes the following data byte.
// RULE23 - Address in lower nibble reads; its data byte is ignored.
// RULE24 - Every control register can be written and read back.
// RULE25 - Upper three bits at 0x14 ignore writes and read as zero.
package scrb_pkg;
    localparam logic [4:0] ADDR_MOTION   = 5'h01;
    localparam logic [4:0] ADDR_CURRENT  = 5'h02;
    localparam logic [4:0] ADDR_DRIVE    = 5'h03;
    localparam logic [4:0] ADDR_TIMEOUT  = 5'h04;
    localparam logic [4:0] ADDR_SPEED    = 5'h05;
    localparam logic [4:0] ADDR_UNDERV   = 5'h06;
    localparam logic [4:0] ADDR_BANK     = 5'h07;
    localparam logic [4:0] ADDR_OPENCOIL = 5'h14;
    localparam logic [4:0] ADDR_BANK_HI  = 5'h17;
    // Field positions
    localparam int BIT_DIR_INV   = 7;
    localparam int BIT_RH_POL    = 6;
    localparam int BIT_STEP      = 5;
    localparam int BIT_BRIDGE    = 4;
    localparam int BIT_ENH_BEMF  = 7;
    localparam int BIT_AUTOCHK   = 6;
    localparam int BIT_SLEEP     = 3;
    localparam int BIT_BANK      = 7;
    localparam int BIT_GAIN      = 6;
    localparam int BIT_BOOST     = 4;
    localparam int BIT_KEEPDRV   = 1;
    localparam int BIT_FLOAT     = 0;
    localparam logic [7:0] OPENCOIL_MASK = 8'h1f;
    // Reset values
    localparam logic [7:0] RST_MOTION   = 8'h00;
    localparam logic [7:0] RST_CURRENT  = 8'h00;
    localparam logic [7:0] RST_DRIVE    = 8'h20;
    localparam logic [7:0] RST_TIMEOUT  = 8'h10;
    localparam logic [7:0] RST_SPEED    = 8'h00;
    localparam logic [7:0] RST_UNDERV   = 8'h00;
    localparam logic [7:0] RST_BANK     = 8'h00;
    localparam logic [7:0] RST_OPENCOIL = 8'h04;
    localparam logic [3:0] FRAME_LAST   = 4'hf;

    typedef struct packed {
        logic       rotation_sense_invert;
        logic       run_hold_polarity;
        logic       bridge_enable;
        logic [3:0] stall_level;
        logic [3:0] hold_current;
        logic [3:0] run_current;
        logic       enhanced_backemf_enable;
        logic       auto_check_enable;
        logic [1:0] slew_rate_select;
        logic       sleep_request;
        logic [2:0] step_resolution_select;
        logic [7:0] stall_timeout;
        logic [7:0] speed_limit;
        logic [3:0] undervolt_level_one;
        logic [3:0] undervolt_level_two;
        logic       backemf_gain_select;
        logic [5:0] irq_enable;
        logic       boost_enable;
        logic [1:0] open_coil_time;
        logic       open_keep_drive;
        logic       open_float;
    } scrb_cfg_s;
endpackage

// File: rtl/scrb_top.sv
/*
 Stepper control register bank: serial slave on the link clock plus
 configuration decode on the system clock.
 Assumes link data sampled on rising sclk, driven on falling sclk; sclk
 stops outside frames; cs_n is active low.
*/
`timescale 1ns/1ps
module scrb_top (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              sdi,
    output logic                   sdo,
    output logic                   sdo_oe,
    input  wire logic              rotation_sense_pin,
    input  wire logic              run_hold_pin,
    input  wire logic [7:0]        speed_value,
    input  wire logic              boost_active,
    input  wire logic              open_coil_seen,
    output scrb_pkg::scrb_cfg_s    cfg,
    output logic                   direction,
    output logic                   hold_mode,
    output logic                   soft_step_trigger,
    output logic                   bridge_on,
    output logic                   auto_check_start,
    output logic                   stall_detect_active,
    output logic                   backemf_active,
    output logic                   open_coil_flag
);
    import scrb_pkg::*;

    // Link domain: frame shifter and register file
    logic [3:0]  bit_cnt;
    logic [6:0]  shift_in;
    logic [7:0]  addr_byte;
    logic [4:0]  read_addr;
    logic [7:0]  tx_shift;
    logic [7:0]  r_motion;
    logic [7:0]  r_current;
    logic [7:0]  r_drive;
    logic [7:0]  r_timeout;
    logic [7:0]  r_speed;
    logic [7:0]  r_underv;
    logic [7:0]  r_bank;
    logic [7:0]  r_opencoil;
    logic        step_toggle;
    logic        cfg_toggle;

    wire  [7:0]  rx_byte   = {shift_in, sdi};
    wire         frame_end = (bit_cnt == FRAME_LAST);
    wire         bank_hi   = r_bank[BIT_BANK];
    // Bank bit supplies the upper address bit
    wire  [4:0]  wr_addr   = {bank_hi, addr_byte[7:4]};   // RULE15
    wire  [4:0]  rd_addr   = {bank_hi, addr_byte[3:0]};   // RULE15
    wire         wr_go     = frame_end;

    // Readback mux; 0x11-0x13 and 0x15-0x17 alias the low registers, other unmapped addresses read zero
    logic [7:0] rd_data;
    always_comb begin
        if (read_addr == ADDR_MOTION || read_addr == (ADDR_MOTION | 5'h10)) begin
            rd_data = r_motion;                               // RULE24
        end else if (read_addr[3:0] == ADDR_CURRENT[3:0]) begin
            rd_data = r_current;
        end else if (read_addr[3:0] == ADDR_DRIVE[3:0]) begin
            rd_data = r_drive;
        end else if (read_addr == ADDR_TIMEOUT) begin
            rd_data = r_timeout;
        end else if (read_addr == ADDR_OPENCOIL) begin
            rd_data = r_opencoil & OPENCOIL_MASK;             // RULE25
        end else if (read_addr[3:0] == ADDR_SPEED[3:0]) begin
            rd_data = r_speed;
        end else if (read_addr[3:0] == ADDR_UNDERV[3:0]) begin
            rd_data = r_underv;
        end else if (read_addr[3:0] == ADDR_BANK[3:0]) begin
            rd_data = r_bank;
        end else begin
            rd_data = 8'h00;
        end
    end

    // Frame bit counter and receive shifter, restarted by chip select
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt  <= 4'h0;
            shift_in <= 7'h00;
        end else begin
            bit_cnt  <= bit_cnt + 4'h1;
            shift_in <= rx_byte[6:0];
        end
    end

    // Address latch; read pointer moves to lower nibble at frame end
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            addr_byte <= 8'h00;
            read_addr <= 5'h00;
        end else begin
            if (bit_cnt == 4'h7) begin
                addr_byte <= rx_byte;
            end
            if (wr_go) begin
                read_addr <= rd_addr;                         // RULE1 RULE23
            end
        end
    end

    // Register writes take the data byte at frame end
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            r_motion    <= RST_MOTION;
            r_current   <= RST_CURRENT;
            r_drive     <= RST_DRIVE;
            r_timeout   <= RST_TIMEOUT;
            r_speed     <= RST_SPEED;
            r_underv    <= RST_UNDERV;
            r_bank      <= RST_BANK;
            r_opencoil  <= RST_OPENCOIL;
            step_toggle <= 1'b0;
            cfg_toggle  <= 1'b0;
        end else if (wr_go) begin
            cfg_toggle <= ~cfg_toggle;                        // Frame landed
            if (wr_addr[3:0] == ADDR_MOTION[3:0]) begin
                r_motion <= rx_byte;                          // RULE22
                if (rx_byte[BIT_STEP]) begin
                    step_toggle <= ~step_toggle;              // RULE4
                end
            end
            if (wr_addr[3:0] == ADDR_CURRENT[3:0]) r_current <= rx_byte;
            if (wr_addr[3:0] == ADDR_DRIVE[3:0]) r_drive <= rx_byte;
            if (wr_addr == ADDR_TIMEOUT) r_timeout <= rx_byte;
            if (wr_addr == ADDR_OPENCOIL) r_opencoil <= rx_byte & OPENCOIL_MASK; // RULE25
            if (wr_addr[3:0] == ADDR_SPEED[3:0]) r_speed <= rx_byte;
            if (wr_addr[3:0] == ADDR_UNDERV[3:0]) r_underv <= rx_byte;
            if (wr_addr[3:0] == ADDR_BANK[3:0]) r_bank <= rx_byte;
        end
    end

    // Transmit: load at byte boundary on falling edge, MSB first
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            tx_shift <= 8'h00;
        end else if (bit_cnt[2:0] == 3'h0) begin
            tx_shift <= rd_data;                              // RULE1
        end else begin
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    // Output enable: on from the first falling edge until deselect
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= 1'b1;
        end
    end
    // Serial out is the shifter's MSB flop itself, moved on falling sclk
    assign sdo = tx_shift[7];

    // System domain: the frame-end toggle passes two flops, then the
    // settled register image is taken whole; sampling the word bit by
    // bit could tear it. Frames must be over three clocks apart.
    logic        cfg_meta;
    logic [1:0]  cfg_seen;
    logic [63:0] cfg_sync;
    logic        step_meta;
    logic [2:0]  step_sync;
    logic [1:0]  pin_meta;
    logic [1:0]  pin_sync;
    wire  [63:0] cfg_link = {r_motion, r_current, r_drive, r_timeout,
                             r_speed, r_underv, r_bank, r_opencoil};
    wire         cfg_take = cfg_seen[1] ^ cfg_seen[0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_meta  <= 1'b0;
            cfg_seen  <= 2'h0;
            cfg_sync  <= {RST_MOTION, RST_CURRENT, RST_DRIVE, RST_TIMEOUT,
                          RST_SPEED, RST_UNDERV, RST_BANK, RST_OPENCOIL};
            step_meta <= 1'b0;
            step_sync <= 3'h0;
            pin_meta  <= 2'h0;
            pin_sync  <= 2'h0;
        end else begin
            cfg_meta  <= cfg_toggle;
            cfg_seen  <= {cfg_seen[0], cfg_meta};
            if (cfg_take) begin
                cfg_sync <= cfg_link;
            end
            step_meta <= step_toggle;
            step_sync <= {step_sync[1:0], step_meta};
            pin_meta  <= {rotation_sense_pin, run_hold_pin};
            pin_sync  <= pin_meta;
        end
    end

    wire [7:0] s_motion   = cfg_sync[63:56];
    wire [7:0] s_current  = cfg_sync[55:48];
    wire [7:0] s_drive    = cfg_sync[47:40];
    wire [7:0] s_timeout  = cfg_sync[39:32];
    wire [7:0] s_speed    = cfg_sync[31:24];
    wire [7:0] s_underv   = cfg_sync[23:16];
    wire [7:0] s_bank     = cfg_sync[15:8];
    wire [7:0] s_opencoil = cfg_sync[7:0];

    // Decode into the carrier
    scrb_cfg_s next_cfg;
    always_comb begin
        next_cfg.rotation_sense_invert   = s_motion[BIT_DIR_INV];
        next_cfg.run_hold_polarity       = s_motion[BIT_RH_POL];
        next_cfg.bridge_enable           = s_motion[BIT_BRIDGE];
        next_cfg.stall_level             = s_motion[3:0];       // RULE6
        next_cfg.hold_current            = s_current[7:4];      // RULE7
        next_cfg.run_current             = s_current[3:0];      // RULE7
        next_cfg.enhanced_backemf_enable = s_drive[BIT_ENH_BEMF]; // RULE8
        next_cfg.auto_check_enable       = s_drive[BIT_AUTOCHK];
        next_cfg.slew_rate_select        = s_drive[5:4];        // RULE10
        next_cfg.sleep_request           = s_drive[BIT_SLEEP];  // RULE11
        next_cfg.step_resolution_select  = s_drive[2:0];        // RULE11
        next_cfg.stall_timeout           = s_timeout;           // RULE12
        next_cfg.speed_limit             = s_speed;
        next_cfg.undervolt_level_one     = s_underv[7:4];       // RULE14
        next_cfg.undervolt_level_two     = s_underv[3:0];       // RULE14
        next_cfg.backemf_gain_select     = s_bank[BIT_GAIN];    // RULE16
        next_cfg.irq_enable              = s_bank[5:0];         // RULE17
        next_cfg.boost_enable            = s_opencoil[BIT_BOOST]; // RULE18
        next_cfg.open_coil_time          = s_opencoil[3:2];     // RULE19
        next_cfg.open_keep_drive         = s_opencoil[BIT_KEEPDRV];
        next_cfg.open_float              = s_opencoil[BIT_FLOAT];
    end

    // Bridge bit of the last cycle, for the rise detector
    logic bridge_on_cfg;
    wire speed_ok     = (speed_value <= s_speed);                       // RULE13
    wire float_now    = open_coil_seen & s_opencoil[BIT_FLOAT]
                        & ~s_opencoil[BIT_KEEPDRV];                     // RULE20 RULE21
    wire next_bridge  = s_motion[BIT_BRIDGE] & ~float_now;              // RULE5
    wire bridge_rise  = s_motion[BIT_BRIDGE] & ~bridge_on_cfg;

    // Registered outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg                 <= '0;
            direction           <= 1'b0;
            hold_mode           <= 1'b0;
            soft_step_trigger   <= 1'b0;
            bridge_on           <= 1'b0;
            bridge_on_cfg       <= 1'b0;
            auto_check_start    <= 1'b0;
            stall_detect_active <= 1'b0;
            backemf_active      <= 1'b0;
            open_coil_flag      <= 1'b0;
        end else begin
            cfg                 <= next_cfg;
            direction           <= pin_sync[1] ^ s_motion[BIT_DIR_INV];        // RULE2
            hold_mode           <= ~(pin_sync[0] ^ s_motion[BIT_RH_POL]);      // RULE3
            soft_step_trigger   <= step_sync[2] ^ step_sync[1];                // RULE4
            bridge_on           <= next_bridge;                                // RULE5
            bridge_on_cfg       <= s_motion[BIT_BRIDGE];
            auto_check_start    <= bridge_rise & s_drive[BIT_AUTOCHK];         // RULE9
            stall_detect_active <= speed_ok & (s_motion[3:0] != 4'h0);         // RULE6 RULE13
            backemf_active      <= speed_ok;                                   // RULE13
            open_coil_flag      <= open_coil_seen;                             // RULE20
            // Boost status reports the analog side's effect when enabled
            if (!s_opencoil[BIT_BOOST]) begin
                cfg.boost_enable <= 1'b0;
            end else begin
                cfg.boost_enable <= boost_active;                              // RULE18
            end
        end
    end
endmodule

// File: testbench/scrb_link_master.sv
/*
 Link master model: 16-bit frames on its own 32 ns link clock.
 Assumes a slave sampling on rising and driving on falling edges.
*/
`timescale 1ns/1ps
module scrb_link_master (
    output logic        sclk,
    output logic        cs_n,
    output logic        sdi,
    input  wire logic   sdo,
    input  wire logic   sdo_oe,
    output logic [15:0] rx_word,
    output logic        rx_valid
);
    // Link clock parks high and runs only inside frames
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b0;
        rx_word = 16'h0000;
        rx_valid = 1'b0;
    end
    // Address byte then data byte, MSB first; short counts for refusal tests
    task automatic frame(input logic [15:0] tx, input int edges);
        logic [15:0] sh;
        sh = 16'h0000;
        cs_n = 1'b0;
        #20;
        for (int i = 0; i < edges; i++) begin
            sclk = 1'b0;
            sdi = tx[15-i];
            #16;
            sclk = 1'b1;
            sh = {sh[14:0], sdo_oe ? sdo : ~sh[0]}; // Undriven line never reads stale
            #16;
        end
        #10;
        cs_n = 1'b1;
        sdi = ~sdi;
        if (edges == 16) begin
            rx_word = sh;
            rx_valid = 1'b1;
            #5;
            rx_valid = 1'b0;
        end
        #40;
    endtask
endmodule

// File: testbench/scrb_top_bench.sv
/*
 Self-checking bench for the stepper register bank over its serial link.
 Assumes the link master model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
module scrb_top_bench;
    import scrb_pkg::*;
    logic       clk, arst_n, rotation_sense_pin, run_hold_pin, boost_active, open_coil_seen;
    logic [7:0] speed_value, d;
    wire        sclk, cs_n, sdi, sdo, sdo_oe, rx_valid;
    wire [15:0] rx_word;
    scrb_cfg_s  cfg;
    logic       direction, hold_mode, soft_step_trigger, bridge_on, auto_check_start;
    logic       stall_detect_active, backemf_active, open_coil_flag;
    int         n_mismatch, num_checks, cycles, n_step, n_chk, e_step, e_chk, n, seed;
    logic [7:0] m [0:31];
    logic [4:0] last_rd;
    logic [8:0] q [$];
    logic [8:0] note;
    scrb_top DUT (.clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .rotation_sense_pin(rotation_sense_pin), .run_hold_pin(run_hold_pin),
        .speed_value(speed_value), .boost_active(boost_active), .open_coil_seen(open_coil_seen),
        .cfg(cfg), .direction(direction), .hold_mode(hold_mode),
        .soft_step_trigger(soft_step_trigger), .bridge_on(bridge_on),
        .auto_check_start(auto_check_start), .stall_detect_active(stall_detect_active),
        .backemf_active(backemf_active), .open_coil_flag(open_coil_flag));
    scrb_link_master u_master (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .rx_word(rx_word), .rx_valid(rx_valid));
    always #25 clk = ~clk;
    task automatic check(input logic [63:0] seen, input logic [63:0] expd);
        num_checks++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, expd);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Cycle ceiling and pulse counters, read on the falling edge where settled
    always @(negedge clk) begin
        cycles++;
        if (soft_step_trigger === 1'b1) n_step++;
        if (auto_check_start === 1'b1) n_chk++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    // Each response is matched against the oldest note
    always @(posedge rx_valid) begin
        note = (q.size() != 0) ? q.pop_front() : 9'h0ff;
        if (!note[8]) check(64'(rx_word), 64'({2{note[7:0]}}));
    end
    function automatic logic [4:0] eff(input logic [3:0] a);
        if (a == 4'h4) return m[7][7] ? 5'h14 : 5'h04;
        return (a >= 4'h1 && a <= 4'h7) ? {1'b0, a} : 5'h00;
    endfunction
    // One frame: note the expected reply, then update the model
    task automatic xfer(input logic [3:0] wa, input logic [3:0] ra, input logic [7:0] v,
                        input logic skip);
        logic [4:0] wr;
        wr = eff(wa);
        q.push_back({skip, m[last_rd]});
        last_rd = eff(ra);
        if (wr == 5'h01 && v[5]) e_step++;
        if (wr == 5'h01 && v[4] && !m[1][4] && m[3][6]) e_chk++;
        if (wr != 5'h00) m[wr] = (wr == 5'h14) ? (v & OPENCOIL_MASK) : v;
        u_master.frame({wa, ra, v}, 16);
    endtask
    task automatic settle_check;
        logic [62:0] ex;
        repeat (8) @(negedge clk);
        ex = {m[1][7], m[1][6], m[1][4], m[1][3:0], m[2], m[3], m[4], m[5], m[6], m[7][6:0],
              m[20][4] & boost_active, m[20][3:0], rotation_sense_pin ^ m[1][7],
              ~(run_hold_pin ^ m[1][6]), (m[1][3:0] != 4'h0) && (speed_value <= m[5]),
              m[1][4] && !(open_coil_seen && m[20][0] && !m[20][1])};
        check(64'({cfg, direction, hold_mode, stall_detect_active, bridge_on}), 64'(ex));
        ex = 63'({speed_value <= m[5], open_coil_seen});
        check(64'({backemf_active, open_coil_flag}), 64'(ex));
    endtask
    initial begin
        {clk, arst_n, rotation_sense_pin, run_hold_pin, boost_active, open_coil_seen} = 6'h00;
        speed_value = 8'h00;
        {n_mismatch, num_checks, cycles, n_step, n_chk, e_step, e_chk} = '0;
        last_rd = 5'h00;
        foreach (m[i]) m[i] = 8'h00;
        {m[1], m[2], m[3], m[4]} = {RST_MOTION, RST_CURRENT, RST_DRIVE, RST_TIMEOUT};
        {m[5], m[6], m[7], m[20]} = {RST_SPEED, RST_UNDERV, RST_BANK, RST_OPENCOIL};
        seed = $urandom(58);
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (6) @(negedge clk);
        settle_check();
        for (int i = 1; i < 8; i++) xfer(4'h0, 4'(i), 8'($urandom), 1'b0);
        xfer(4'h7, 4'h0, 8'h80, 1'b0);
        xfer(4'h0, 4'h4, 8'h00, 1'b0);
        xfer(4'h7, 4'h0, 8'h00, 1'b0);
        $display("test reset values done");
        for (int i = 0; i < 35; i++) begin
            n = (i % 7) + 1;
            d = 8'($urandom);
            if (n == 1) d[7:6] = 2'(i / 7);
            if (n == 7) d[7] = 1'b0;
            @(negedge clk);
            {rotation_sense_pin, run_hold_pin, boost_active, open_coil_seen} = 4'($urandom);
            speed_value = 8'($urandom);
            xfer(4'(n), 4'(n), d, 1'b0);
            xfer(4'h0, 4'(n), 8'($urandom), 1'b0);
            settle_check();
        end
        check(64'(n_step), 64'(e_step));
        check(64'(n_chk), 64'(e_chk));
        $display("test random writes done");
        xfer(4'h7, 4'h0, 8'h80, 1'b0);
        xfer(4'h1, 4'h0, 8'h10, 1'b0);
        @(negedge clk);
        {boost_active, open_coil_seen} = 2'b11;
        for (int i = 0; i < 4; i++) begin
            xfer(4'h4, 4'h4, {4'hf, 2'(i + 1), 2'(i)}, 1'b0);
            settle_check();
        end
        xfer(4'h7, 4'h7, 8'h00, 1'b0);
        xfer(4'h0, 4'h4, 8'h00, 1'b0);
        $display("test bank select done");
        u_master.frame({4'h2, 4'h0, 8'h5a}, 8);
        xfer(4'h0, 4'h2, 8'h00, 1'b0);
        xfer(4'h0, 4'h0, 8'h00, 1'b0);
        $display("test short frame done");
        test_done();
    end
endmodule
bind scrb_top scrb_top_sva u_sva (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sdo_oe(sdo_oe),
    .rotation_sense_pin(rotation_sense_pin), .run_hold_pin(run_hold_pin),
    .speed_value(speed_value), .boost_active(boost_active), .open_coil_seen(open_coil_seen),
    .cfg(cfg), .direction(direction), .hold_mode(hold_mode),
    .soft_step_trigger(soft_step_trigger), .bridge_on(bridge_on),
    .auto_check_start(auto_check_start), .stall_detect_active(stall_detect_active),
    .backemf_active(backemf_active), .open_coil_flag(open_coil_flag));

// File: testbench/scrb_top_sva.sv
/*
 Checker for the stepper register bank outputs on the system clock.
 Assumes it is bound to scrb_top and sees only its ports.
*/
`timescale 1ns/1ps
module scrb_top_sva (
    input wire logic                clk,
    input wire logic                arst_n,
    input wire logic                cs_n,
    input wire logic                sdo_oe,
    input wire logic                rotation_sense_pin,
    input wire logic                run_hold_pin,
    input wire logic [7:0]          speed_value,
    input wire logic                boost_active,
    input wire logic                open_coil_seen,
    input wire scrb_pkg::scrb_cfg_s cfg,
    input wire logic                direction,
    input wire logic                hold_mode,
    input wire logic                soft_step_trigger,
    input wire logic                bridge_on,
    input wire logic                auto_check_start,
    input wire logic                stall_detect_active,
    input wire logic                backemf_active,
    input wire logic                open_coil_flag
);
    import scrb_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Quiet windows long enough for sync and decode flops to settle
    sequence s_quiet;
        ($stable(cfg) && $stable(speed_value) && $stable(open_coil_seen))[*3];
    endsequence
    sequence s_pins_quiet;
        ($stable(cfg) && $stable(rotation_sense_pin) && $stable(run_hold_pin))[*5];
    endsequence
    a_dir_polarity: assert property (s_pins_quiet |->
        direction == (rotation_sense_pin ^ cfg.rotation_sense_invert)) else $error("dir bad");
    a_hold_polarity: assert property (s_pins_quiet |->
        hold_mode == !(run_hold_pin ^ cfg.run_hold_polarity)) else $error("hold bad");
    a_stall_gate: assert property (s_quiet |-> stall_detect_active ==
        (cfg.stall_level != 4'h0 && speed_value <= cfg.speed_limit)) else $error("stall bad");
    a_bemf_gate: assert property ((s_quiet ##0 backemf_active) |->
        speed_value <= cfg.speed_limit) else $error("bemf bad");
    a_bridge_follow: assert property (s_quiet |-> bridge_on == (cfg.bridge_enable &&
        !(open_coil_seen && cfg.open_float && !cfg.open_keep_drive))) else $error("bridge bad");
    a_open_flag: assert property ((s_quiet ##0 open_coil_seen && cfg.open_keep_drive) |->
        open_coil_flag) else $error("open flag bad");
    a_boost_report: assert property (($stable(boost_active)[*3] ##0 cfg.boost_enable) |->
        boost_active) else $error("boost bad");
    a_step_pulse: assert property (soft_step_trigger |=> !soft_step_trigger)
        else $error("step pulse too long");
    a_check_pulse: assert property (auto_check_start |->
        cfg.auto_check_enable ##1 !auto_check_start) else $error("check pulse bad");
    a_oe_release: assert property ((cs_n && $past(cs_n)) |-> !sdo_oe)
        else $error("sdo driven outside frame");
endmodule
